// [flash_ctrl_pkg.sv]
// Purpose: Shared constants for the flash write and erase controller.
// Assumes: APB register access, 20 MHz pclk.
// Notes:   Offsets are byte addresses within the controller window.
package flash_ctrl_pkg;
   localparam logic [11:0] OFS_READY_STATUS   = 12'h400;
   localparam logic [11:0] OFS_WRITE_BUF_FREE = 12'h408;
   localparam logic [11:0] OFS_ACCESS_MODE    = 12'h504;
   localparam logic [11:0] OFS_PAGE_ERASE     = 12'h508;
   localparam logic [11:0] OFS_FULL_ERASE     = 12'h50c;
   localparam logic [11:0] OFS_PAGE_ERASE_B   = 12'h510;
   localparam logic [11:0] OFS_UCFG_ERASE     = 12'h514;
   localparam logic [11:0] OFS_PARTIAL_ERASE  = 12'h518;
   localparam logic [11:0] OFS_PARTIAL_DUR    = 12'h51c;
   localparam logic [11:0] OFS_STATUS_EXTRA   = 12'h600;

   localparam logic [1:0]  MODE_READ_ONLY     = 2'h0;
   localparam logic [1:0]  MODE_WRITE_EN      = 2'h1;
   localparam logic [1:0]  MODE_ERASE_EN      = 2'h2;
   localparam logic [1:0]  MODE_RESET         = 2'h0;
   localparam logic [31:0] READY_RESET        = 32'h0000_0001;
   localparam logic [31:0] WBUF_FREE_RESET    = 32'h0000_0001;
   localparam logic [31:0] PARTIAL_DUR_RESET  = 32'h0000_000a;

   localparam int CLK_HZ           = 20000000;
   localparam int WRITE_TIME_NS    = 42500;
   localparam int PAGE_ERASE_US    = 87500;
   localparam int FULL_ERASE_US    = 173000;
   // Longest times round down to whole cycles.
   localparam int WRITE_CYCLES     = (WRITE_TIME_NS / 50);
   localparam int PAGE_ERASE_CYC   = (PAGE_ERASE_US / 1000) * (CLK_HZ / 1000)
                                     + ((PAGE_ERASE_US % 1000) * (CLK_HZ / 1000)) / 1000;
   localparam int FULL_ERASE_CYC   = (FULL_ERASE_US / 1000) * (CLK_HZ / 1000);
   localparam int MS_CYCLES        = CLK_HZ / 1000;

   typedef enum logic [5:0] {
      ST_IDLE    = 6'b00_0001,
      ST_WRITE   = 6'b00_0010,
      ST_PAGE    = 6'b00_0100,
      ST_PARTIAL = 6'b00_1000,
      ST_UCFG    = 6'b01_0000,
      ST_FULL    = 6'b10_0000
   } op_state_t;
endpackage : flash_ctrl_pkg

// [flash_write_erase_controller.sv]
// Purpose: Sequences word writes and erases of the flash array and the
//          user configuration area, with APB control registers.
// Assumes: Array ports are synchronous; one array command at a time.
// Notes:   Timing counts are parameters so that short runs stay practical.
// Function
// - Writes only in write-enable mode, erases only in erase-enable mode.
// - Only full aligned 32-bit words are taken as program operations.
// - Programming only clears bits; stored data is ANDed with new word.
// - Byte or half-word program access raises a hard fault.
// - Processor fetch stalls while any operation runs.
// - With buffer free, next word is buffered and starts after current.
// - Page erase trigger erases one page to all ones.
// - Configuration writes take effect only after next reset.
// - Configuration erase sets area to ones in page erase time.
// - Full erase clears flash and configuration area, not factory area.
// - Protection blocks only the configuration erase command.
// - Power fail below threshold blocks every write and erase.
// - Erase request under power-fail warning is silently ignored.
// - Write under power-fail warning raises a hard fault.
// - Partial erase applies only to code pages.
// - Partial slices accumulate; reaching page erase time erases and counts cycle.
// - Partially erased page reads undefined until time is reached.
// - Ready bit reads 0 while busy, 1 idle, resets to 1.
// - Buffer-free bit reads 1 when a write can be taken.
// - Durations stay within write, page and full erase limits.
`timescale 1ns/100ps
`default_nettype none
module flash_write_erase_controller
   import flash_ctrl_pkg::*;
#(
   parameter int ADDR_W       = 18,
   parameter int PAGE_BITS    = 12,
   parameter int WRITE_CYC    = WRITE_CYCLES,
   parameter int PAGE_CYC     = PAGE_ERASE_CYC,
   parameter int FULL_CYC     = FULL_ERASE_CYC,
   parameter int MS_CYC       = MS_CYCLES
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              mem_wr_valid,
   input  wire logic              mem_wr_ucfg,
   input  wire logic [ADDR_W-1:0] mem_wr_addr,
   input  wire logic [31:0]       mem_wr_data,
   input  wire logic [3:0]        mem_wr_strb,
   output logic                   mem_wr_ready,
   input  wire logic              fetch_req,
   output logic                   fetch_stall,
   output logic                   hard_fault,
   input  wire logic              access_port_protection,
   input  wire logic              pof_enable,
   input  wire logic              pof_warning,
   output logic                   arr_prog,
   output logic                   arr_ucfg,
   output logic [ADDR_W-1:0]      arr_addr,
   output logic [31:0]            arr_data,
   output logic                   arr_page_erase,
   output logic                   arr_ucfg_erase,
   output logic                   arr_full_erase,
   output logic                   arr_busy,
   output logic                   page_undefined,
   output logic [15:0]            erase_cycle_count,
   output logic                   ucfg_reload
);
   initial begin
      if (ADDR_W < PAGE_BITS + 1 || PAGE_BITS < 2 || WRITE_CYC < 1 || PAGE_CYC < 1
          || FULL_CYC < 1 || MS_CYC < 1) begin
         $error("flash_write_erase_controller: unsupported parameters");
      end
   end

   op_state_t             state_ff;
   logic [1:0]            mode_ff;
   logic [31:0]           pdur_ff;
   logic [31:0]           timer_ff;
   logic [31:0]           acc_ff;
   logic [ADDR_W-1:0]     ppage_ff;
   logic                  pactive_ff;
   logic                  buf_vld_ff;
   logic                  buf_ucfg_ff;
   logic [ADDR_W-1:0]     buf_addr_ff;
   logic [31:0]           buf_data_ff;
   logic                  ucfg_dirty_ff;
   logic                  wr_pulse;
   logic                  pof_block;
   logic                  erase_ok;
   logic                  wr_full;
   logic                  timer_done;
   logic [ADDR_W-1:0]     page_of_wdata;
   logic [31:0]           slice_cyc;

   function automatic logic [ADDR_W-1:0] page_base(input logic [31:0] a);
      logic [ADDR_W-1:0] r;
      r = a[ADDR_W-1:0];
      r[PAGE_BITS-1:0] = '0;
      return r;
   endfunction : page_base

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   assign pready        = 1'b1;
   assign wr_pulse      = psel && penable && pwrite;
   assign page_of_wdata = page_base(pwdata);
   assign pof_block     = pof_enable && pof_warning;
   assign timer_done    = (timer_ff == 32'h0000_0001);
   assign slice_cyc     = 32'(pdur_ff * 32'(MS_CYC));

   always_comb begin
      prdata  = 32'h0000_0000;
      pslverr = 1'b0;
      case (paddr)
         OFS_READY_STATUS:   prdata = {31'h0000_0000, state_ff == ST_IDLE};
         OFS_WRITE_BUF_FREE: prdata = {31'h0000_0000, !buf_vld_ff};
         OFS_ACCESS_MODE:    prdata = {30'h0000_0000, mode_ff};
         OFS_PARTIAL_DUR:    prdata = pdur_ff;
         OFS_STATUS_EXTRA:   prdata = {15'h0000, page_undefined, erase_cycle_count};
         OFS_PAGE_ERASE, OFS_FULL_ERASE, OFS_PAGE_ERASE_B, OFS_UCFG_ERASE,
         OFS_PARTIAL_ERASE:  prdata = 32'h0000_0000;
         default:            pslverr = psel && penable;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ff <= MODE_RESET;
         pdur_ff <= PARTIAL_DUR_RESET;
      end else if (wr_pulse && paddr == OFS_ACCESS_MODE) begin
         mode_ff <= pwdata[1:0];
      end else if (wr_pulse && paddr == OFS_PARTIAL_DUR) begin
         pdur_ff <= pwdata;
      end
   end

   // ---------------------------------------------------------------
   // Word write intake
   // ---------------------------------------------------------------
   // full word only
   assign wr_full      = (mem_wr_strb == 4'hf) && (mem_wr_addr[1:0] == 2'b00);
   assign mem_wr_ready = !buf_vld_ff;
   assign erase_ok     = (mode_ff == MODE_ERASE_EN) && !pof_block;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hard_fault <= 1'b0;
      end else begin
         hard_fault <= mem_wr_valid && !buf_vld_ff && mode_ff == MODE_WRITE_EN
                       && (!wr_full || pof_block);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         buf_vld_ff  <= 1'b0;
         buf_ucfg_ff <= 1'b0;
         buf_addr_ff <= '0;
         buf_data_ff <= 32'h0000_0000;
      end else if (mem_wr_valid && !buf_vld_ff && mode_ff == MODE_WRITE_EN
                   && wr_full && !pof_block) begin
         buf_vld_ff  <= 1'b1;
         buf_ucfg_ff <= mem_wr_ucfg;
         buf_addr_ff <= mem_wr_addr;
         buf_data_ff <= mem_wr_data;
      end else if (state_ff == ST_IDLE && buf_vld_ff) begin
         buf_vld_ff  <= 1'b0;
      end else if (state_ff == ST_WRITE && timer_done && buf_vld_ff) begin
         buf_vld_ff  <= 1'b0;
      end
   end

   // ---------------------------------------------------------------
   // Operation sequencer
   // ---------------------------------------------------------------
   // timed operations
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_IDLE;
         timer_ff <= 32'h0000_0000;
         arr_addr <= '0;
         arr_data <= 32'h0000_0000;
         arr_ucfg <= 1'b0;
      end else begin
         case (state_ff)
            ST_IDLE: begin
               if (buf_vld_ff) begin
                  state_ff <= ST_WRITE;
                  timer_ff <= 32'(WRITE_CYC);
                  arr_addr <= buf_addr_ff;
                  arr_data <= buf_data_ff;
                  arr_ucfg <= buf_ucfg_ff;
               end else if (wr_pulse && erase_ok) begin
                  if (paddr == OFS_PAGE_ERASE || paddr == OFS_PAGE_ERASE_B) begin
                     state_ff <= ST_PAGE;
                     timer_ff <= 32'(PAGE_CYC);
                     arr_addr <= page_of_wdata;
                  end else if (paddr == OFS_FULL_ERASE && pwdata[0]) begin
                     state_ff <= ST_FULL;
                     timer_ff <= 32'(FULL_CYC);
                  end else if (paddr == OFS_UCFG_ERASE && pwdata[0]
                               && !access_port_protection) begin
                     state_ff <= ST_UCFG;
                     timer_ff <= 32'(PAGE_CYC);
                  end else if (paddr == OFS_PARTIAL_ERASE && pdur_ff != 32'h0000_0000) begin
                     state_ff <= ST_PARTIAL;
                     timer_ff <= slice_cyc;
                     arr_addr <= page_of_wdata;
                  end
               end
            end
            ST_WRITE: begin
               if (timer_done) begin
                  if (buf_vld_ff) begin
                     timer_ff <= 32'(WRITE_CYC);
                     arr_addr <= buf_addr_ff;
                     arr_data <= buf_data_ff;
                     arr_ucfg <= buf_ucfg_ff;
                  end else begin
                     state_ff <= ST_IDLE;
                  end
               end else begin
                  timer_ff <= timer_ff - 32'h0000_0001;
               end
            end
            ST_PAGE, ST_PARTIAL, ST_UCFG, ST_FULL: begin
               if (timer_done) begin
                  state_ff <= ST_IDLE;
               end else begin
                  timer_ff <= timer_ff - 32'h0000_0001;
               end
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Array strobes and stall
   // ---------------------------------------------------------------
   // array applies AND of old and new data
   assign arr_prog       = (state_ff == ST_WRITE) && timer_done;
   assign arr_page_erase = ((state_ff == ST_PAGE) && timer_done)
                           || ((state_ff == ST_PARTIAL) && timer_done
                               && acc_ff + slice_cyc >= 32'(PAGE_CYC));
   assign arr_ucfg_erase = (state_ff == ST_UCFG) && timer_done;
   assign arr_full_erase = (state_ff == ST_FULL) && timer_done;
   assign arr_busy       = (state_ff != ST_IDLE);
   assign fetch_stall    = fetch_req && (state_ff != ST_IDLE);

   // ---------------------------------------------------------------
   // Partial erase accumulation
   // ---------------------------------------------------------------
   // accumulate slices
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_ff            <= 32'h0000_0000;
         ppage_ff          <= '0;
         pactive_ff        <= 1'b0;
         erase_cycle_count <= 16'h0000;
      end else if (state_ff == ST_IDLE && wr_pulse && erase_ok
                   && paddr == OFS_PARTIAL_ERASE && pdur_ff != 32'h0000_0000
                   && !buf_vld_ff && page_of_wdata != ppage_ff) begin
         acc_ff     <= 32'h0000_0000;
         ppage_ff   <= page_of_wdata;
         pactive_ff <= 1'b1;
      end else if (state_ff == ST_IDLE && wr_pulse && erase_ok && !buf_vld_ff
                   && paddr == OFS_PARTIAL_ERASE && pdur_ff != 32'h0000_0000) begin
         pactive_ff <= 1'b1;
      end else if (state_ff == ST_PARTIAL && timer_done) begin
         if (arr_page_erase) begin
            acc_ff            <= 32'h0000_0000;
            pactive_ff        <= 1'b0;
            erase_cycle_count <= erase_cycle_count + 16'h0001;
         end else begin
            acc_ff <= acc_ff + slice_cyc;
         end
      end else if (state_ff == ST_PARTIAL) begin
         acc_ff <= acc_ff;
      end else if (arr_full_erase || (arr_page_erase && arr_addr == ppage_ff)) begin
         // Only an erase that covers the sliced page makes it defined again.
         acc_ff     <= 32'h0000_0000;
         pactive_ff <= 1'b0;
      end
   end
   assign page_undefined = pactive_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ucfg_dirty_ff <= 1'b0;
      end else if ((arr_prog && arr_ucfg) || arr_ucfg_erase || arr_full_erase) begin
         ucfg_dirty_ff <= 1'b1;
      end
   end
   // Tells the system that changed configuration waits for the next reset.
   assign ucfg_reload = ucfg_dirty_ff;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   property p_ready_idle;
      @(posedge pclk) disable iff (!presetn)
         (paddr == OFS_READY_STATUS) |-> (prdata[0] == (state_ff == ST_IDLE));
   endproperty
   a_ready_idle: assert property (p_ready_idle) else $error("ready bit wrong");

   property p_buf_free;
      @(posedge pclk) disable iff (!presetn)
         (paddr == OFS_WRITE_BUF_FREE) |-> (prdata[0] == mem_wr_ready);
   endproperty
   a_buf_free: assert property (p_buf_free) else $error("buffer free bit wrong");

   property p_no_erase_wrong_mode;
      @(posedge pclk) disable iff (!presetn)
         (state_ff == ST_IDLE && mode_ff != MODE_ERASE_EN && !buf_vld_ff)
         |=> (state_ff == ST_IDLE || state_ff == ST_WRITE);
   endproperty
   a_no_erase_wrong_mode: assert property (p_no_erase_wrong_mode) else $error("erase without mode");

   property p_protect_ucfg;
      @(posedge pclk) disable iff (!presetn)
         (state_ff == ST_IDLE && access_port_protection) |=> (state_ff != ST_UCFG);
   endproperty
   a_protect_ucfg: assert property (p_protect_ucfg) else $error("protected erase ran");

   property p_pof_erase;
      @(posedge pclk) disable iff (!presetn)
         (state_ff == ST_IDLE && pof_block && !buf_vld_ff) |=> (state_ff == ST_IDLE);
   endproperty
   a_pof_erase: assert property (p_pof_erase) else $error("erase under power fail");

   property p_byte_fault;
      @(posedge pclk) disable iff (!presetn)
         (mem_wr_valid && mem_wr_ready && mode_ff == MODE_WRITE_EN && !wr_full)
         |=> (hard_fault && !buf_vld_ff);
   endproperty
   a_byte_fault: assert property (p_byte_fault) else $error("partial word accepted");

   property p_stall;
      @(posedge pclk) disable iff (!presetn)
         (fetch_req && state_ff != ST_IDLE) |-> fetch_stall;
   endproperty
   a_stall: assert property (p_stall) else $error("fetch not stalled");

   property p_write_time;
      @(posedge pclk) disable iff (!presetn)
         $rose(state_ff == ST_WRITE) |-> (timer_ff <= 32'(WRITE_CYC));
   endproperty
   a_write_time: assert property (p_write_time) else $error("write too long");

   property p_chain;
      @(posedge pclk) disable iff (!presetn)
         (arr_prog && buf_vld_ff) |=> (state_ff == ST_WRITE && !buf_vld_ff);
   endproperty
   a_chain: assert property (p_chain) else $error("buffered write not chained");

   c_write: cover property (@(posedge pclk) disable iff (!presetn) arr_prog);
   c_page:  cover property (@(posedge pclk) disable iff (!presetn) arr_page_erase);
   c_full:  cover property (@(posedge pclk) disable iff (!presetn) arr_full_erase);
   c_fault: cover property (@(posedge pclk) disable iff (!presetn) hard_fault);
endmodule : flash_write_erase_controller
`default_nettype wire

// [flash_array_model.sv]
// Purpose: Behavioural flash array and configuration area behind the controller.
// Assumes: Array strobes are one-cycle pulses sampled on pclk.
// Notes:   Unwritten words read as erased ones.
`timescale 1ns/100ps
`default_nettype none
module flash_array_model
   import flash_ctrl_pkg::*;
#(
   parameter int ADDR_W    = 18,
   parameter int PAGE_BITS = 12
) (
   input wire logic              pclk,
   input wire logic              arr_prog,
   input wire logic              arr_ucfg,
   input wire logic [ADDR_W-1:0] arr_addr,
   input wire logic [31:0]       arr_data,
   input wire logic              arr_page_erase,
   input wire logic              arr_ucfg_erase,
   input wire logic              arr_full_erase
);
   logic [31:0] code_mem [int];
   logic [31:0] ucfg_mem [int];
   int          prog_cnt = 0;

   function automatic logic [31:0] rd(input int a, input logic u);
      if (u) begin
         return ucfg_mem.exists(a) ? ucfg_mem[a] : 32'hffff_ffff;
      end
      return code_mem.exists(a) ? code_mem[a] : 32'hffff_ffff;
   endfunction : rd

   always @(posedge pclk) begin
      if (arr_prog === 1'b1) begin
         prog_cnt++;
         if (arr_ucfg) ucfg_mem[int'(arr_addr)] = rd(int'(arr_addr), 1'b1) & arr_data;
         else code_mem[int'(arr_addr)] = rd(int'(arr_addr), 1'b0) & arr_data;
      end
      if (arr_page_erase === 1'b1) begin
         foreach (code_mem[k]) begin
            if ((k >> PAGE_BITS) == (int'(arr_addr) >> PAGE_BITS)) code_mem[k] = 32'hffff_ffff;
         end
      end
      if (arr_ucfg_erase === 1'b1) ucfg_mem.delete();
      if (arr_full_erase === 1'b1) begin
         code_mem.delete();
         ucfg_mem.delete();
      end
   end
endmodule : flash_array_model
`default_nettype wire

// [flash_write_erase_controller_tb.sv]
// Purpose: Self-checking bench for the flash write and erase controller.
// Assumes: Shortened operation counts; zero-wait APB slave.
// Notes:   Random word data from a fixed seed.
`timescale 1ns/100ps
`default_nettype none
module flash_write_erase_controller_tb;
   import flash_ctrl_pkg::*;
   localparam int WC = 4, PC = 50, FC = 80, MC = 5;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hf;
   logic mem_wr_valid, mem_wr_ucfg, mem_wr_ready, fetch_req, fetch_stall, hard_fault;
   logic access_port_protection, pof_enable, pof_warning, arr_prog, arr_ucfg, arr_busy;
   logic arr_page_erase, arr_ucfg_erase, arr_full_erase, page_undefined, ucfg_reload;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, mem_wr_data, arr_data, d0, d1, d2;
   logic [17:0] mem_wr_addr, arr_addr;
   logic [3:0]  mem_wr_strb;
   logic [15:0] erase_cycle_count;
   int          n_errors, checks_done, seed, n;

   flash_write_erase_controller #(.WRITE_CYC(WC), .PAGE_CYC(PC), .FULL_CYC(FC), .MS_CYC(MC))
   flash_write_erase_controller_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .mem_wr_valid, .mem_wr_ucfg, .mem_wr_addr,
      .mem_wr_data, .mem_wr_strb, .mem_wr_ready, .fetch_req, .fetch_stall, .hard_fault,
      .access_port_protection, .pof_enable, .pof_warning, .arr_prog, .arr_ucfg, .arr_addr,
      .arr_data, .arr_page_erase, .arr_ucfg_erase, .arr_full_erase, .arr_busy,
      .page_undefined, .erase_cycle_count, .ucfg_reload);
   flash_array_model flash_array_model_inst (.pclk, .arr_prog, .arr_ucfg, .arr_addr,
      .arr_data, .arr_page_erase, .arr_ucfg_erase, .arr_full_erase);

   task automatic end_sim;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : end_sim

   task automatic tmo;
      n_errors++;
      $display("mismatch t=%0t wait timed out", $time);
      end_sim();
   endtask : tmo

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   // Expected cell contents after a program: bits only ever clear.
   function automatic logic [31:0] exp_prog(input logic [31:0] old_w, input logic [31:0] new_w);
      return old_w & new_w;
   endfunction : exp_prog

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      for (i = 0; i < 20; i++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (i == 20) tmo();
      rd = prdata;
      hf = pslverr;
      psel <= 0; penable <= 0;
      @(posedge pclk);
   endtask : apb

   task automatic mw(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic u);
      int i;
      mem_wr_valid <= 1; mem_wr_addr <= a; mem_wr_data <= d; mem_wr_strb <= s; mem_wr_ucfg <= u;
      for (i = 0; i < 200; i++) begin
         @(posedge pclk);
         if (mem_wr_ready === 1'b1) break;
      end
      if (i == 200) tmo();
      mem_wr_valid <= 0;
      #1 hf = hard_fault;
      @(posedge pclk);
   endtask : mw

   // Counts busy cycles while toggling fetches and checking the stall.
   task automatic wait_idle(output int cnt);
      cnt = 0;
      for (int i = 0; i < 2000; i++) begin
         @(posedge pclk);
         fetch_req <= 1'($random(seed));
         #1 chk(fetch_stall, fetch_req & arr_busy, "fetch stall");
         if (arr_busy !== 1'b1) begin
            fetch_req <= 0;
            @(posedge pclk);
            return;
         end
         cnt++;
      end
      tmo();
   endtask : wait_idle

   initial begin
      pclk = 0;
      forever #25 pclk = ~pclk;
   end

   initial begin
      seed = 42; n_errors = 0; checks_done = 0; presetn = 0; psel = 0; penable = 0;
      pwrite = 0; paddr = 0; pwdata = 0; mem_wr_valid = 0; mem_wr_ucfg = 0; mem_wr_addr = 0;
      mem_wr_data = 0; mem_wr_strb = 0; fetch_req = 0; access_port_protection = 0;
      pof_enable = 0; pof_warning = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      apb(0, OFS_READY_STATUS, 0); chk(rd, READY_RESET, "ready reset");
      apb(0, OFS_WRITE_BUF_FREE, 0); chk(rd, WBUF_FREE_RESET, "buffer free reset");
      apb(0, 12'h7fc, 0); chk(hf, 1, "unmapped error");
      apb(1, OFS_ACCESS_MODE, 32'(MODE_WRITE_EN));
      apb(0, OFS_ACCESS_MODE, 0); chk(rd[1:0], MODE_WRITE_EN, "mode readback");
      d0 = $random(seed); d1 = $random(seed); d2 = $random(seed);
      mw(18'h0_3010, d0, 4'hf, 0); mw(18'h0_2000, d1, 4'hf, 0);
      mw(18'h0_0100, d2, 4'hf, 0); mw(18'h0_3010, d1, 4'hf, 0);
      wait_idle(n); chk(n <= 3 * WC + 2, 1, "buffered writes");
      chk(flash_array_model_inst.prog_cnt, 4, "write count");
      chk(flash_array_model_inst.rd(32'h3010, 0), exp_prog(d0, d1), "and on rewrite");
      mw(18'h0_3018, 0, 4'h3, 0); chk(hf, 1, "partial strobe fault");
      mw(18'h0_301a, 0, 4'hf, 0); chk(hf, 1, "misaligned fault");
      pof_enable <= 1; pof_warning <= 1;
      mw(18'h0_3018, 0, 4'hf, 0); chk(hf, 1, "power fail fault");
      chk(flash_array_model_inst.prog_cnt, 4, "nothing written");
      pof_enable <= 0; pof_warning <= 0;
      mw(18'h0_0010, d1, 4'hf, 1); wait_idle(n);
      chk(flash_array_model_inst.rd(32'h10, 1), d1, "config word");
      chk(ucfg_reload, 1, "config waits for reset");
      d0 = {16'hffff, d2[15:0]};
      mw(18'h0_0010, d0, 4'hf, 1); wait_idle(n);
      chk(flash_array_model_inst.rd(32'h10, 1), exp_prog(d1, d0), "upper half kept");
      apb(1, OFS_PAGE_ERASE, 32'h3000);
      apb(0, OFS_READY_STATUS, 0); chk(rd, 1, "erase in write mode");
      apb(1, OFS_ACCESS_MODE, 32'(MODE_ERASE_EN));
      pof_enable <= 1; pof_warning <= 1;
      apb(1, OFS_PAGE_ERASE, 32'h3000);
      apb(0, OFS_READY_STATUS, 0); chk(rd, 1, "erase under power fail");
      pof_enable <= 0; pof_warning <= 0; access_port_protection <= 1;
      apb(1, OFS_UCFG_ERASE, 1);
      apb(0, OFS_READY_STATUS, 0); chk(rd, 1, "config erase blocked");
      apb(1, OFS_PAGE_ERASE_B, 32'h3ffc);
      apb(0, OFS_READY_STATUS, 0); chk(rd, 0, "busy in erase");
      wait_idle(n); chk(n <= PC + 2, 1, "page erase time");
      chk(flash_array_model_inst.rd(32'h3010, 0), 32'hffff_ffff, "page erased");
      chk(flash_array_model_inst.rd(32'h2000, 0), d1, "other page kept");
      access_port_protection <= 0;
      apb(1, OFS_UCFG_ERASE, 1); wait_idle(n); chk(n <= PC + 2, 1, "config erase time");
      chk(flash_array_model_inst.rd(32'h10, 1), 32'hffff_ffff, "config erased");
      apb(1, OFS_PARTIAL_DUR, 4); apb(0, OFS_PARTIAL_DUR, 0); chk(rd, 4, "slice readback");
      for (int k = 0; k < 3; k++) begin
         apb(1, OFS_PARTIAL_ERASE, 32'h2004); wait_idle(n);
         chk(n <= 4 * MC + 2, 1, "slice time");
         chk(page_undefined, k < 2, "page undefined");
      end
      apb(0, OFS_STATUS_EXTRA, 0); chk(rd[16:0], 17'h1, "one erase cycle");
      chk(flash_array_model_inst.rd(32'h2000, 0), 32'hffff_ffff, "partial done");
      apb(1, OFS_FULL_ERASE, 1); wait_idle(n); chk(n <= FC + 2, 1, "full erase time");
      chk(flash_array_model_inst.rd(32'h100, 0), 32'hffff_ffff, "full erased");
      presetn <= 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      @(posedge pclk);
      chk(ucfg_reload, 0, "reload done at reset");
      apb(0, OFS_ACCESS_MODE, 0); chk(rd[1:0], MODE_RESET, "mode after reset");
      apb(0, OFS_PARTIAL_DUR, 0); chk(rd, PARTIAL_DUR_RESET, "slice after reset");
      end_sim();
   end
endmodule : flash_write_erase_controller_tb
`default_nettype wire
